// [pkg/bus_map_pkg.sv]
/*
 Address map, access timing and carrier types of the on-chip bus access unit.
 Assumes a 16-bit address space with memories and I/O registers behind one select bus.
*/
package bus_map_pkg;
   localparam logic [15:0] ROM_START       = 16'h0000;
   localparam logic [15:0] ROM_END_32K     = 16'h7fff;
   localparam logic [15:0] ROM_END_40K     = 16'h9fff;
   localparam logic [15:0] ROM_END_48K     = 16'hbfff;
   localparam logic [15:0] ROM_END_60K     = 16'hedff;
   localparam logic [15:0] LCD_BASE0       = 16'hf740;
   localparam logic [15:0] LCD_SPAN        = 16'h003f;
   localparam logic [15:0] RAM_START_1K    = 16'hfb80;
   localparam logic [15:0] RAM_START_2K    = 16'hf780;
   localparam logic [15:0] RAM_END         = 16'hff7f;
   localparam logic [15:0] RAM_BLOCK_LO    = 16'hfb80;
   localparam logic [15:0] RAM_BLOCK_HI    = 16'hfd7f;
   localparam logic [15:0] SBUF_LO         = 16'hff80;
   localparam logic [15:0] SBUF_HI         = 16'hff9f;
   localparam logic [15:0] IO_LO           = 16'hffa0;
   localparam logic [15:0] IO_HI           = 16'hffff;
   localparam logic [15:0] SLOW_LO         = 16'hffa8;
   localparam logic [15:0] SLOW_HI         = 16'hffad;
   localparam logic [15:0] WINDOW_POS_ADDR = 16'hffcf;
   localparam logic [7:0]  WINDOW_POS_RST  = 8'hfc;
   localparam logic [5:0]  WINDOW_FIXED    = 6'h3f;
   localparam logic [15:0] TMR_ADDR        = 16'hffb0;
   localparam logic [7:0]  TMR_RESET       = 8'h00;
   localparam logic [7:0]  UNDEF_BYTE      = 8'h00;
   localparam logic [1:0]  FAST_LEFT       = 2'h1;
   localparam logic [1:0]  SLOW_LEFT       = 2'h2;

   typedef enum logic [2:0] {
      OP_READ  = 3'h0,
      OP_WRITE = 3'h1,
      OP_BSET  = 3'h2,
      OP_BCLR  = 3'h3,
      OP_BNOT  = 3'h4,
      OP_BST   = 3'h5
   } op_t;

   typedef enum logic [4:0] {
      SEL_NONE = 5'h00,
      SEL_ROM  = 5'h01,
      SEL_LCD  = 5'h02,
      SEL_RAM  = 5'h04,
      SEL_SBUF = 5'h08,
      SEL_IO   = 5'h10
   } sel_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } state_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        word;
      op_t         op;
   } cpu_req_t;

   typedef struct packed {
      sel_t        sel;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        we;
      logic        word;
   } tgt_t;
endpackage

// [verilog/addr_window.sv]
/*
 Inclusive address range comparator.
 Assumes bounds and address come from logic on the same clock.
*/
`timescale 1ns/100ps
module addr_window (
   input  wire logic [15:0] addr,
   input  wire logic [15:0] lo,
   input  wire logic [15:0] hi,
   output wire logic        hit
);
   assign hit = (addr >= lo) && (addr <= hi);
endmodule

// [verilog/bus_access_unit.sv]
/*
 Address decoder and bus access sequencer between CPU core and on-chip targets.
 Assumes targets answer tgt_rdata while selected; byte data sits in the low lane.
*/
// Overview of operation
// - After reset the display window decodes F740 to F77F.
// - Window position lives in a readable, writable byte register at FFCF.
// - Position register resets to FC: select bits zero, upper bits one.
// - Position register bits 7..2 read one and ignore writes.
// - Select codes 00..11 place the 64-byte window at F740, F940, FB40, FD40.
// - Small RAM variant with code 11 loses RAM FB80 to FD7F.
// - Large RAM variant loses overlapped RAM for any code but 00.
// - Writes to empty addresses store nothing.
// - Reads from empty addresses return undefined data.
// - Byte-path regions keep only the upper byte of a word write.
// - Word read of I/O other than timer FFB0 and position FFCF gives register byte high, undefined byte low.
// - ROM, display memory and RAM take byte and word accesses in two states.
// - Serial buffer FF80..FF9F takes byte accesses only, two states.
// - I/O region is byte only; FFA8..FFAD take three states, rest two.
// - ROM ends at 7FFF, 9FFF, BFFF or EDFF by variant.
// - RAM starts FB80 (small) or F780 (large), ends below serial buffer.
// - Bit instructions read the byte, change one bit, write it back.
// - Timer shared address: reads give live count, writes go to reload.
`timescale 1ns/100ps
module bus_access_unit
   import bus_map_pkg::*;
#(
   parameter logic [1:0] ROM_SIZE  = 2'h0,
   parameter logic       RAM_LARGE = 1'b0
) (
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        cpu_valid,
   input  wire cpu_req_t    cpu_req,
   output logic             cpu_ready,
   output logic             cpu_done,
   output logic [15:0]      cpu_rdata,
   output tgt_t             tgt,
   input  wire logic [15:0] tgt_rdata,
   output logic [1:0]       lcd_window
);
   state_t      state;
   state_t      next_state;
   logic [1:0]  left;
   logic [1:0]  next_left;
   cpu_req_t    acc;
   cpu_req_t    next_acc;
   logic        acc_slow;
   logic        next_acc_slow;
   logic        acc_pos;
   logic        next_acc_pos;
   logic        acc_tmr;
   logic        next_acc_tmr;
   logic        acc_wide;
   logic        next_acc_wide;
   tgt_t        next_tgt;
   logic        next_cpu_ready;
   logic        next_cpu_done;
   logic [15:0] next_cpu_rdata;
   logic [1:0]  window_sel;
   logic [1:0]  next_window_sel;
   logic [7:0]  tmr_count;
   logic [7:0]  next_tmr_count;
   logic [7:0]  tmr_reload;
   logic [7:0]  next_tmr_reload;

   logic [15:0] rom_end;
   logic [15:0] ram_lo;
   logic [15:0] lcd_lo;
   logic [15:0] lcd_hi;
   logic        rom_hit;
   logic        lcd_hit;
   logic        ram_raw;
   logic        blk_hit;
   logic        sbuf_hit;
   logic        io_hit;
   logic        slow_hit;
   logic        ram_hit;
   sel_t        dec_sel;
   logic        dec_pos;
   logic        dec_tmr;
   logic        bit_op;
   logic [15:0] rd16;
   logic [7:0]  mask;
   logic [7:0]  mbyte;
   logic [7:0]  lane;

   always_comb begin
      case (ROM_SIZE)
         2'h1:    rom_end = ROM_END_40K;
         2'h2:    rom_end = ROM_END_48K;
         2'h3:    rom_end = ROM_END_60K;
         default: rom_end = ROM_END_32K;
      endcase
   end

   assign ram_lo = RAM_LARGE ? RAM_START_2K : RAM_START_1K;
   assign lcd_lo = LCD_BASE0 + {5'h00, window_sel, 9'h000};
   assign lcd_hi = lcd_lo + LCD_SPAN;

   addr_window u_rom (
      .addr (cpu_req.addr),
      .lo   (ROM_START),
      .hi   (rom_end),
      .hit  (rom_hit)
   );
   addr_window u_lcd (
      .addr (cpu_req.addr),
      .lo   (lcd_lo),
      .hi   (lcd_hi),
      .hit  (lcd_hit)
   );
   addr_window u_ram (
      .addr (cpu_req.addr),
      .lo   (ram_lo),
      .hi   (RAM_END),
      .hit  (ram_raw)
   );
   addr_window u_blk (
      .addr (cpu_req.addr),
      .lo   (RAM_BLOCK_LO),
      .hi   (RAM_BLOCK_HI),
      .hit  (blk_hit)
   );
   addr_window u_sbuf (
      .addr (cpu_req.addr),
      .lo   (SBUF_LO),
      .hi   (SBUF_HI),
      .hit  (sbuf_hit)
   );
   addr_window u_io (
      .addr (cpu_req.addr),
      .lo   (IO_LO),
      .hi   (IO_HI),
      .hit  (io_hit)
   );
   addr_window u_slow (
      .addr (cpu_req.addr),
      .lo   (SLOW_LO),
      .hi   (SLOW_HI),
      .hit  (slow_hit)
   );

   // Window beats RAM; small part also loses the block under code 11
   assign ram_hit = ram_raw && !lcd_hit
                    && !(blk_hit && !RAM_LARGE && window_sel == 2'h3);

   always_comb begin
      if (rom_hit)       dec_sel = SEL_ROM;
      else if (lcd_hit)  dec_sel = SEL_LCD;
      else if (ram_hit)  dec_sel = SEL_RAM;
      else if (sbuf_hit) dec_sel = SEL_SBUF;
      else if (io_hit)   dec_sel = SEL_IO;
      else               dec_sel = SEL_NONE;
   end

   assign dec_pos = cpu_req.addr == WINDOW_POS_ADDR;
   assign dec_tmr = cpu_req.addr == TMR_ADDR;
   assign bit_op  = cpu_req.op inside {OP_BSET, OP_BCLR, OP_BNOT, OP_BST};
   assign lane    = cpu_req.word ? cpu_req.wdata[15:8] : cpu_req.wdata[7:0];

   // Read data as the CPU sees it, per region path width
   always_comb begin
      if (acc_pos)
         rd16 = {8'h00, WINDOW_FIXED, window_sel};
      else if (acc_tmr)
         rd16 = {8'h00, tmr_count};
      else if (tgt.sel == SEL_NONE)
         rd16 = {UNDEF_BYTE, UNDEF_BYTE};
      else if (acc_wide)
         rd16 = acc.word ? tgt_rdata : {8'h00, tgt_rdata[7:0]};
      else
         rd16 = acc.word ? {tgt_rdata[7:0], UNDEF_BYTE}
                         : {8'h00, tgt_rdata[7:0]};
   end

   always_comb begin
      mask = 8'h01 << acc.wdata[2:0];
      case (acc.op)
         OP_BSET: mbyte = rd16[7:0] | mask;
         OP_BCLR: mbyte = rd16[7:0] & ~mask;
         OP_BNOT: mbyte = rd16[7:0] ^ mask;
         OP_BST:  mbyte = acc.wdata[3] ? (rd16[7:0] | mask) : (rd16[7:0] & ~mask);
         default: mbyte = rd16[7:0];
      endcase
   end

   always_comb begin
      next_state      = state;
      next_left       = left;
      next_acc        = acc;
      next_acc_slow   = acc_slow;
      next_acc_pos    = acc_pos;
      next_acc_tmr    = acc_tmr;
      next_acc_wide   = acc_wide;
      next_tgt        = tgt;
      next_cpu_done   = 1'b0;
      next_cpu_rdata  = cpu_rdata;
      next_window_sel = window_sel;
      next_tmr_reload = tmr_reload;
      case (state)
         ST_IDLE: begin
            if (cpu_valid) begin
               next_acc      = cpu_req;
               next_acc.word = cpu_req.word && !bit_op;
               next_acc_slow = slow_hit;
               next_acc_pos  = dec_pos;
               next_acc_tmr  = dec_tmr;
               next_acc_wide = dec_sel inside {SEL_ROM, SEL_LCD, SEL_RAM};
               next_left     = slow_hit ? SLOW_LEFT : FAST_LEFT;
               next_tgt.sel  = (dec_pos || dec_tmr) ? SEL_NONE : dec_sel;
               next_tgt.addr = cpu_req.addr;
               next_tgt.we   = cpu_req.op == OP_WRITE;
               if (dec_sel inside {SEL_ROM, SEL_LCD, SEL_RAM}) begin
                  next_tgt.word  = cpu_req.word && !bit_op;
                  next_tgt.wdata = cpu_req.wdata;
               end else begin
                  // Byte path: a word write keeps only its upper byte
                  next_tgt.word  = 1'b0;
                  next_tgt.wdata = {8'h00, lane};
               end
               next_state = (cpu_req.op == OP_WRITE) ? ST_WRITE : ST_READ;
            end
         end
         ST_READ: begin
            if (left != 2'h0) begin
               next_left = left - 2'h1;
            end else if (acc.op != OP_READ) begin
               next_tgt.we    = 1'b1;
               next_tgt.wdata = {8'h00, mbyte};
               next_left      = acc_slow ? SLOW_LEFT : FAST_LEFT;
               next_state     = ST_WRITE;
            end else begin
               next_cpu_rdata = rd16;
               next_cpu_done  = 1'b1;
               next_tgt.sel   = SEL_NONE;
               next_tgt.we    = 1'b0;
               next_state     = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (left != 2'h0) begin
               next_left = left - 2'h1;
            end else begin
               if (acc_pos)
                  next_window_sel = tgt.wdata[1:0];
               if (acc_tmr)
                  next_tmr_reload = tgt.wdata[7:0];
               next_cpu_done = 1'b1;
               next_tgt.sel  = SEL_NONE;
               next_tgt.we   = 1'b0;
               next_state    = ST_IDLE;
            end
         end
         default: begin
            next_state   = ST_IDLE;
            next_tgt.sel = SEL_NONE;
            next_tgt.we  = 1'b0;
         end
      endcase
      next_cpu_ready = next_state == ST_IDLE;
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state      <= ST_IDLE;
         left       <= 2'h0;
         acc        <= '0;
         acc_slow   <= 1'b0;
         acc_pos    <= 1'b0;
         acc_tmr    <= 1'b0;
         acc_wide   <= 1'b0;
         tgt        <= '0;
         cpu_ready  <= 1'b1;
         cpu_done   <= 1'b0;
         cpu_rdata  <= 16'h0000;
         window_sel <= WINDOW_POS_RST[1:0];
         tmr_reload <= TMR_RESET;
      end else begin
         state      <= next_state;
         left       <= next_left;
         acc        <= next_acc;
         acc_slow   <= next_acc_slow;
         acc_pos    <= next_acc_pos;
         acc_tmr    <= next_acc_tmr;
         acc_wide   <= next_acc_wide;
         tgt        <= next_tgt;
         cpu_ready  <= next_cpu_ready;
         cpu_done   <= next_cpu_done;
         cpu_rdata  <= next_cpu_rdata;
         window_sel <= next_window_sel;
         tmr_reload <= next_tmr_reload;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst)
         lcd_window <= WINDOW_POS_RST[1:0];
      else
         lcd_window <= next_window_sel;
   end

   // Free-running down counter; reloads on reaching zero
   always_comb begin
      next_tmr_count = (tmr_count == 8'h00) ? tmr_reload : tmr_count - 8'h01;
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst)
         tmr_count <= TMR_RESET;
      else
         tmr_count <= next_tmr_count;
   end

   sequence s_take_fast;
      state == ST_IDLE && cpu_valid && !slow_hit && !bit_op;
   endsequence
   sequence s_take_slow;
      state == ST_IDLE && cpu_valid && slow_hit && !bit_op;
   endsequence
   sequence s_take_bit;
      state == ST_IDLE && cpu_valid && !slow_hit && bit_op && !dec_pos && !dec_tmr;
   endsequence

   reset_window_a: assert property (@(posedge ref_clk)
      !$past(nrst) |-> window_sel == 2'h0 && lcd_window == 2'h0)
      else $error("window not at base after reset");

   fixed_ones_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      cpu_done && acc_pos && acc.op == OP_READ |-> cpu_rdata[7:2] == WINDOW_FIXED)
      else $error("position register upper bits not one");

   two_state_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_take_fast |-> ##1 !cpu_done [*2] ##1 cpu_done)
      else $error("two-state access timing wrong");

   three_state_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_take_slow |-> ##1 !cpu_done [*3] ##1 cpu_done)
      else $error("three-state access timing wrong");

   empty_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      state == ST_IDLE && cpu_valid && dec_sel == SEL_NONE
      |=> (tgt.sel == SEL_NONE) [*2])
      else $error("empty address selected a target");

   io_word_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_take_fast and (io_hit && !dec_pos && !dec_tmr && cpu_req.word
      && cpu_req.op == OP_READ) |-> ##3 cpu_rdata[7:0] == UNDEF_BYTE)
      else $error("word read of I/O low byte wrong");

   byte_path_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      state == ST_IDLE && cpu_valid && (sbuf_hit || io_hit) && cpu_req.op == OP_WRITE
      |=> !tgt.word && tgt.wdata[7:0] == $past(lane))
      else $error("byte-path write lane wrong");

   lcd_route_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      state == ST_IDLE && cpu_valid && lcd_hit && !rom_hit |=> tgt.sel == SEL_LCD)
      else $error("window address not routed to display memory");

   rmw_order_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      s_take_bit |-> ##1 (!tgt.we) [*2] ##1 tgt.we [*2] ##1 cpu_done)
      else $error("bit instruction not read then write");

   reload_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      state == ST_WRITE && left == 2'h0 && acc_tmr |=> tmr_reload == $past(tgt.wdata[7:0]))
      else $error("timer write missed reload register");
endmodule

// [sim/tgt_model.sv]
/*
 Behavioural model of the on-chip targets behind the access unit.
 Assumes one flat byte array, word data high byte first, byte data in the low lane.
*/
`timescale 1ns/100ps
module tgt_model
   import bus_map_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire tgt_t        tgt,
   output logic [15:0]      tgt_rdata
);
   bit   [7:0]  mem [65536];
   logic [15:0] idle_pat = 16'h5aa5;

   // Unselected bus churns so stale data cannot pass for an answer
   always @(posedge ref_clk) begin
      idle_pat <= ~idle_pat;
      if (tgt.sel != SEL_NONE && tgt.we) begin
         if (tgt.word) begin
            mem[tgt.addr]       <= tgt.wdata[15:8];
            mem[tgt.addr+16'h1] <= tgt.wdata[7:0];
         end else begin
            mem[tgt.addr] <= tgt.wdata[7:0];
         end
      end
   end

   always_comb begin
      if (tgt.sel == SEL_NONE)
         tgt_rdata = idle_pat;
      else if (tgt.word)
         tgt_rdata = {mem[tgt.addr], mem[tgt.addr+16'h1]};
      else
         tgt_rdata = {8'h00, mem[tgt.addr]};
   end
endmodule

// [sim/tb.sv]
/*
 Self-checking bench for the bus access unit: window relocation, map, timing, bit ops.
 Assumes tgt_model answers for every target; built as 40k ROM with 2k RAM.
 A 60k ROM, 1k RAM twin runs in lockstep and has only its select checked.
*/
`timescale 1ns/100ps
module tb
   import bus_map_pkg::*;
;
   logic        ref_clk;
   logic        nrst;
   logic        cpu_valid;
   cpu_req_t    cpu_req;
   logic        cpu_ready;
   logic        cpu_done;
   logic [15:0] cpu_rdata;
   tgt_t        tgt;
   tgt_t        tgt_small;
   sel_t        s_small;
   logic [15:0] tgt_rdata;
   logic [1:0]  lcd_window;
   logic [1:0]  code;
   bit   [7:0]  shd [65536];
   logic [15:0] offs [4] = '{16'hffff, 16'h0000, 16'h003f, 16'h0040};
   int          error_cnt;
   int          cmp_count;

   bus_access_unit #(.ROM_SIZE(2'h1), .RAM_LARGE(1'b1)) bus_access_unit_inst (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .cpu_valid  (cpu_valid),
      .cpu_req    (cpu_req),
      .cpu_ready  (cpu_ready),
      .cpu_done   (cpu_done),
      .cpu_rdata  (cpu_rdata),
      .tgt        (tgt),
      .tgt_rdata  (tgt_rdata),
      .lcd_window (lcd_window)
   );

   // Small-RAM variant: same requests, select compared only
   bus_access_unit #(.ROM_SIZE(2'h3), .RAM_LARGE(1'b0)) bus_access_unit_small_inst (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .cpu_valid  (cpu_valid),
      .cpu_req    (cpu_req),
      .cpu_ready  (),
      .cpu_done   (),
      .cpu_rdata  (),
      .tgt        (tgt_small),
      .tgt_rdata  (tgt_rdata),
      .lcd_window ()
   );

   tgt_model tgt_model_inst (
      .ref_clk   (ref_clk),
      .tgt       (tgt),
      .tgt_rdata (tgt_rdata)
   );

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   function automatic sel_t exp_sel(logic [15:0] a, logic [1:0] c, logic big);
      logic [15:0] b;
      b = LCD_BASE0 + {5'h00, c, 9'h000};
      if (a <= (big ? ROM_END_40K : ROM_END_60K))
         return SEL_ROM;
      if (a >= b && a <= b + LCD_SPAN)
         return SEL_LCD;
      if (a >= (big ? RAM_START_2K : RAM_START_1K) && a <= RAM_END
          && (big || c != 2'h3 || a > RAM_BLOCK_HI))
         return SEL_RAM;
      if (a >= SBUF_LO && a <= SBUF_HI)
         return SEL_SBUF;
      if (a == WINDOW_POS_ADDR || a == TMR_ADDR)
         return SEL_NONE;
      if (a >= IO_LO)
         return SEL_IO;
      return SEL_NONE;
   endfunction

   function automatic logic [15:0] exp_rd(logic [15:0] a, logic w);
      sel_t       s;
      logic [7:0] b;
      s = exp_sel(a, code, 1'b1);
      b = (a == WINDOW_POS_ADDR) ? {WINDOW_FIXED, code} : shd[a];
      if (s == SEL_NONE && a != WINDOW_POS_ADDR)
         return 16'h0000;
      if (!w)
         return {8'h00, b};
      if (s == SEL_ROM || s == SEL_LCD || s == SEL_RAM)
         return {b, shd[a+16'h1]};
      return {b, UNDEF_BYTE};
   endfunction

   function automatic logic [7:0] bitop(op_t op, logic [7:0] b, logic [15:0] d);
      logic [7:0] m;
      m = 8'h01 << d[2:0];
      case (op)
         OP_BSET: return b | m;
         OP_BCLR: return b & ~m;
         OP_BNOT: return b ^ m;
         default: return d[3] ? (b | m) : (b & ~m);
      endcase
   endfunction

   task automatic results();
      $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk_data(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_sel(input sel_t got, input sel_t exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: select got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_cyc(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: cycles got %0d exp %0d", $time, got, exp);
      end
   endtask

   // Entered just after an edge with the unit idle; leaves just after the done edge
   task automatic acc(input op_t op, input logic [15:0] a, input logic [15:0] d,
                      input logic w, output logic [15:0] rd, output sel_t s, output int n);
      cpu_req   = '{addr: a, wdata: d, word: w, op: op};
      cpu_valid = 1'b1;
      n = 1;
      @(posedge ref_clk);
      #1;
      cpu_valid = 1'b0;
      s = tgt.sel;
      s_small = tgt_small.sel;
      while (cpu_done !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      rd = cpu_rdata;
   endtask

   task automatic run(input op_t op, input logic [15:0] a, input logic [15:0] d, input logic w);
      logic [15:0] rd;
      logic [15:0] er;
      logic [7:0]  b;
      sel_t        s;
      sel_t        es;
      int          n;
      int          st;
      er = exp_rd(a, w);
      es = exp_sel(a, code, 1'b1);
      st = (a >= SLOW_LO && a <= SLOW_HI) ? 3 : 2;
      acc(op, a, d, w, rd, s, n);
      chk_sel(s, es);
      chk_sel(s_small, exp_sel(a, code, 1'b0));
      chk_cyc(n, (op >= OP_BSET) ? 2 * st + 1 : st + 1);
      if (op == OP_READ)
         chk_data(rd, er, "read data");
      if (op != OP_READ && a == WINDOW_POS_ADDR) begin
         b = (op == OP_WRITE) ? (w ? d[15:8] : d[7:0]) : bitop(op, {WINDOW_FIXED, code}, d);
         code = b[1:0];
      end else if (op == OP_WRITE && es != SEL_NONE) begin
         if (w && (es == SEL_SBUF || es == SEL_IO)) begin
            shd[a] = d[15:8];
         end else if (w) begin
            shd[a] = d[15:8];
            shd[a+16'h1] = d[7:0];
         end else begin
            shd[a] = d[7:0];
         end
      end else if (op != OP_READ && es != SEL_NONE) begin
         shd[a] = bitop(op, shd[a], d);
      end
   endtask

   initial begin
      logic [15:0] d;
      logic [15:0] a;
      logic [15:0] base;
      logic [15:0] r1;
      logic [15:0] r2;
      logic        w;
      op_t         op;
      sel_t        s;
      int          n;
      nrst = 1'b0;
      cpu_valid = 1'b0;
      cpu_req = '0;
      code = 2'h0;
      error_cnt = 0;
      cmp_count = 0;
      void'($urandom(76324));
      repeat (8) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      chk_data({14'h0, lcd_window}, 16'h0000, "window code");
      chk_data({15'h0, cpu_ready}, 16'h0001, "ready");
      run(OP_READ, WINDOW_POS_ADDR, 16'h0, 1'b0);
      run(OP_READ, LCD_BASE0, 16'h0, 1'b1);
      run(OP_READ, ROM_END_40K, 16'h0, 1'b0);
      run(OP_READ, ROM_END_40K + 16'h1, 16'h0, 1'b0);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         d = 16'($urandom);
         d[1:0] = c[1:0];
         run(OP_WRITE, WINDOW_POS_ADDR, d, 1'b0);
         chk_data({14'h0, lcd_window}, {14'h0, code}, "window code");
         run(OP_READ, WINDOW_POS_ADDR, 16'h0, 1'b0);
         base = LCD_BASE0 + {5'h00, code, 9'h000};
         foreach (offs[i]) begin
            run(OP_WRITE, base + offs[i], 16'($urandom), 1'b0);
            run(OP_READ, base + offs[i], 16'h0, 1'b0);
         end
         run(OP_READ, base, 16'h0, 1'b1);
      end
      $display("test window done");
      for (a = 16'hffa6; a < 16'hffaf; a++) begin
         run(OP_WRITE, a, 16'($urandom), 1'b1);
         for (int k = 2; k < 6; k++)
            run(op_t'(k), a, 16'($urandom), 1'b0);
         run(OP_READ, a, 16'h0, 1'b1);
      end
      $display("test io done");
      run(OP_WRITE, TMR_ADDR, 16'h00ff, 1'b0);
      repeat (300) @(posedge ref_clk);
      #1;
      acc(OP_READ, TMR_ADDR, 16'h0, 1'b0, r1, s, n);
      acc(OP_READ, TMR_ADDR, 16'h0, 1'b0, r2, s, n);
      chk_data({8'h00, r1[7:0] - r2[7:0]}, 16'h0003, "timer step");
      $display("test timer done");
      for (int i = 0; i < 500; i++) begin
         op = op_t'($urandom_range(0, 5));
         a = ($urandom_range(0, 1) == 1) ? 16'($urandom) : 16'hf700 + 16'($urandom_range(0, 2303));
         w = (op <= OP_WRITE) ? 1'($urandom) : 1'b0;
         if (w)
            a[0] = 1'b0;
         if (a == TMR_ADDR)
            a = a + 16'h2;
         if (op != OP_READ && a <= ROM_END_40K)
            op = OP_READ;
         run(op, a, 16'($urandom), w);
      end
      $display("test random done");
      results();
   end

   // Whole run needs well under 10000 cycles
   initial begin
      #(40 * 30000);
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      results();
   end
endmodule
